// ### inc/pxmd_regs.vh
`ifndef PXMD_REGS_VH
`define PXMD_REGS_VH

// Opcodes handled here
`define PXMD_OP_LDPG 6'h2C
`define PXMD_OP_STPG 6'h2D
`define PXMD_OP_DMUL 6'h2E
`define PXMD_OP_DDIV 6'h2F

// Instruction forms
`define PXMD_FORM_RR 2'h0
`define PXMD_FORM_RI 2'h1
`define PXMD_FORM_RK 2'h2
`define PXMD_FORM_RX 2'h3

// Page map entry fields
`define PXMD_PG_IDX_MSB 5
`define PXMD_PG_CNT_MSB 13
`define PXMD_PG_CNT_LSB 8
`define PXMD_PG_ZERO_FILL 9'h000
`define PXMD_PG_ENTRIES 64

// Condition code values
`define PXMD_CC_ZERO 2'h0
`define PXMD_CC_POS 2'h1
`define PXMD_CC_NEG 2'h2
`define PXMD_CC_OVF 2'h3

// Sequencer states
`define PXMD_S_IDLE 3'h0
`define PXMD_S_RD 3'h1
`define PXMD_S_DISP 3'h2
`define PXMD_S_MEM 3'h3
`define PXMD_S_EXEC 3'h4
`define PXMD_S_WR 3'h5
`define PXMD_S_DONE 3'h6

// Register operand reads: Ra..Ra+3, Rm, Rm+1
`define PXMD_RD_LAST 3'h5
`define PXMD_WR_LAST 2'h3

`endif

// ### hw/pxmd_core.v
`timescale 1ns/10ps
`include "pxmd_regs.vh"

module pxmd_core (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire start,
    input wire [5:0] opcode,
    input wire [1:0] form,
    input wire [3:0] accum_reg_select,
    input wire [3:0] source_reg_select,
    input wire [15:0] y_addr,
    output reg [3:0] rf_raddr_r,
    input wire [15:0] rf_rdata,
    output reg rf_we_r,
    output reg [3:0] rf_waddr_r,
    output reg [15:0] rf_wdata_r,
    output reg mem_req_r,
    output reg mem_we_r,
    output reg [15:0] mem_addr_r,
    output reg [15:0] mem_wdata_r,
    input wire mem_ack,
    input wire [15:0] mem_rdata,
    input wire [5:0] map_idx,
    output reg [15:0] map_data_r,
    output reg busy_r,
    output reg done_r,
    output reg undef_r,
    output reg cc_we_r,
    output reg [1:0] cc_r
);

    // Page map storage; middle bits are never stored
    reg [15:0] page_mem [0:`PXMD_PG_ENTRIES-1];

    // Latched instruction
    reg [2:0] state_r;
    reg [5:0] op_r;
    reg [1:0] form_r;
    reg [3:0] a_r;
    reg [3:0] m_r;
    reg [15:0] y_r;

    // Operand buffers and loop counters
    reg [15:0] rbuf_r [0:5];
    reg [15:0] wbuf_r [0:3];
    reg [15:0] opnd_r [0:1];
    reg [2:0] rd_n_r;
    reg [1:0] wr_n_r;
    reg [5:0] pidx_r;
    reg [6:0] cnt_r;

    // Page write port
    reg pg_we;
    reg [15:0] pg_wdata;
    wire [5:0] pg_waddr;
    wire [15:0] pg_in;
    wire [6:0] blk_cnt;
    wire is_pg;

    // Arithmetic operands
    wire signed [31:0] acc32;
    wire signed [31:0] opr32;
    wire signed [63:0] prod;
    wire signed [63:0] dvd;
    wire signed [63:0] dvs;
    wire signed [63:0] quo;
    wire signed [63:0] rem;
    wire div0;
    wire [3:0] rd_next;

    // Middle bits forced to zero on every store
    assign pg_in = {pg_wdata[15], `PXMD_PG_ZERO_FILL, pg_wdata[5:0]};
    // Index is latched in the same cycle, so the register form takes it from the buffer
    assign pg_waddr = (state_r == `PXMD_S_DISP) ? rbuf_r[0][`PXMD_PG_IDX_MSB:0] : pidx_r;
    assign is_pg = (op_r == `PXMD_OP_LDPG) || (op_r == `PXMD_OP_STPG);

    // Count field plus one, so zero moves one entry
    assign blk_cnt = {1'b0, rbuf_r[0][`PXMD_PG_CNT_MSB:`PXMD_PG_CNT_LSB]} + 7'h01;

    // Ra is the most significant word and carries the sign
    assign acc32 = {rbuf_r[0], rbuf_r[1]};
    assign opr32 = {opnd_r[0], opnd_r[1]};
    assign prod = acc32 * opr32;
    assign dvd = {rbuf_r[0], rbuf_r[1], rbuf_r[2], rbuf_r[3]};
    assign dvs = {{32{opr32[31]}}, opr32};
    assign div0 = (opr32 == 32'h00000000);

    // Guarded so a zero divisor gives a zero quotient and remainder
    assign quo = div0 ? 64'sh0000000000000000 : dvd / dvs;
    assign rem = div0 ? 64'sh0000000000000000 : dvd % dvs;

    // Next register read: Ra..Ra+3 then Rm, Rm+1
    assign rd_next = (rd_n_r < 3'h3) ? a_r + {1'b0, rd_n_r[1:0]} + 4'h1 :
                     (rd_n_r == 3'h3) ? m_r : m_r + 4'h1;

    // Page map write port, single writer
    always @(posedge clk)
    begin
        if (ce && pg_we)
        begin
            page_mem[pg_waddr] <= pg_in;
        end
    end

    // Lookup port for address translation
    always @(posedge clk)
    begin
        if (rst)
        begin
            map_data_r <= 16'h0000;
        end
        else if (ce)
        begin
            map_data_r <= page_mem[map_idx];
        end
    end

    // Page write decision, from the sequencer state
    always @*
    begin
        pg_we = 1'b0;
        pg_wdata = rbuf_r[4];
        if (op_r == `PXMD_OP_LDPG)
        begin
            if (state_r == `PXMD_S_DISP && form_r == `PXMD_FORM_RR)
            begin
                pg_we = 1'b1;
            end
            else if (state_r == `PXMD_S_MEM && mem_ack)
            begin
                pg_we = 1'b1;
                pg_wdata = mem_rdata;
            end
        end
    end

    // Main sequencer
    always @(posedge clk)
    begin
        if (rst)
        begin
            state_r <= `PXMD_S_IDLE;
            op_r <= 6'h00;
            form_r <= 2'h0;
            a_r <= 4'h0;
            m_r <= 4'h0;
            y_r <= 16'h0000;
            rd_n_r <= 3'h0;
            wr_n_r <= 2'h0;
            pidx_r <= 6'h00;
            cnt_r <= 7'h00;
            rf_raddr_r <= 4'h0;
            rf_we_r <= 1'b0;
            rf_waddr_r <= 4'h0;
            rf_wdata_r <= 16'h0000;
            mem_req_r <= 1'b0;
            mem_we_r <= 1'b0;
            mem_addr_r <= 16'h0000;
            mem_wdata_r <= 16'h0000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            undef_r <= 1'b0;
            cc_we_r <= 1'b0;
            cc_r <= `PXMD_CC_ZERO;
        end
        else if (ce)
        begin
            // Pulses default low
            rf_we_r <= 1'b0;
            done_r <= 1'b0;
            undef_r <= 1'b0;
            cc_we_r <= 1'b0;
            case (state_r)
                `PXMD_S_IDLE:
                begin
                    if (start)
                    begin
                        op_r <= opcode;
                        form_r <= form;
                        a_r <= accum_reg_select;
                        m_r <= source_reg_select;
                        y_r <= y_addr;
                        // Undefined forms finish at once with nothing touched
                        if (form == `PXMD_FORM_RK || opcode < `PXMD_OP_LDPG || opcode > `PXMD_OP_DDIV)
                        begin
                            done_r <= 1'b1;
                            undef_r <= 1'b1;
                        end
                        else
                        begin
                            busy_r <= 1'b1;
                            rf_raddr_r <= accum_reg_select;
                            rd_n_r <= 3'h0;
                            state_r <= `PXMD_S_RD;
                        end
                    end
                end
                `PXMD_S_RD:
                begin
                    // Data for last cycle's address arrives now
                    rbuf_r[rd_n_r] <= rf_rdata;
                    rf_raddr_r <= rd_next;
                    rd_n_r <= rd_n_r + 3'h1;
                    if (rd_n_r == `PXMD_RD_LAST)
                    begin
                        state_r <= `PXMD_S_DISP;
                    end
                end
                `PXMD_S_DISP:
                begin
                    pidx_r <= rbuf_r[0][`PXMD_PG_IDX_MSB:0];
                    state_r <= `PXMD_S_MEM;
                    mem_req_r <= 1'b1;
                    mem_we_r <= 1'b0;
                    mem_addr_r <= y_r;
                    cnt_r <= 7'h02;
                    if (is_pg && form_r == `PXMD_FORM_RR)
                    begin
                        mem_req_r <= 1'b0;
                        state_r <= `PXMD_S_DONE;
                        if (op_r == `PXMD_OP_STPG)
                        begin
                            rf_we_r <= 1'b1;
                            rf_waddr_r <= m_r;
                            rf_wdata_r <= page_mem[rbuf_r[0][`PXMD_PG_IDX_MSB:0]];
                        end
                    end
                    else if (is_pg)
                    begin
                        // Single indirect transfer or a counted block
                        mem_we_r <= (op_r == `PXMD_OP_STPG);
                        mem_wdata_r <= page_mem[rbuf_r[0][`PXMD_PG_IDX_MSB:0]];
                        if (form_r == `PXMD_FORM_RI)
                        begin
                            mem_addr_r <= rbuf_r[4];
                            cnt_r <= 7'h01;
                        end
                        else
                        begin
                            cnt_r <= blk_cnt;
                        end
                    end
                    else if (form_r == `PXMD_FORM_RR)
                    begin
                        // Register pair operand, no memory needed
                        mem_req_r <= 1'b0;
                        opnd_r[0] <= rbuf_r[4];
                        opnd_r[1] <= rbuf_r[5];
                        state_r <= `PXMD_S_EXEC;
                    end
                end
                `PXMD_S_MEM:
                begin
                    if (mem_ack)
                    begin
                        // Walk memory and page index together
                        mem_addr_r <= mem_addr_r + 16'h0001;
                        pidx_r <= pidx_r + 6'h01;
                        mem_wdata_r <= page_mem[pidx_r + 6'h01];
                        cnt_r <= cnt_r - 7'h01;
                        // Operand pair shifts in: Y then Y+1
                        opnd_r[0] <= opnd_r[1];
                        opnd_r[1] <= mem_rdata;
                        if (cnt_r == 7'h01)
                        begin
                            mem_req_r <= 1'b0;
                            mem_we_r <= 1'b0;
                            state_r <= is_pg ? `PXMD_S_DONE : `PXMD_S_EXEC;
                        end
                    end
                end
                `PXMD_S_EXEC:
                begin
                    wr_n_r <= 2'h0;
                    cc_we_r <= 1'b1;
                    state_r <= `PXMD_S_WR;
                    if (op_r == `PXMD_OP_DMUL)
                    begin
                        wbuf_r[0] <= prod[63:48];
                        wbuf_r[1] <= prod[47:32];
                        wbuf_r[2] <= prod[31:16];
                        wbuf_r[3] <= prod[15:0];
                        cc_r <= (prod == 64'h0000000000000000) ? `PXMD_CC_ZERO :
                                prod[63] ? `PXMD_CC_NEG : `PXMD_CC_POS;
                    end
                    else if (div0)
                    begin
                        // Zero divisor: leave registers alone, flag it
                        cc_r <= `PXMD_CC_OVF;
                        state_r <= `PXMD_S_DONE;
                    end
                    else
                    begin
                        wbuf_r[0] <= rem[31:16];
                        wbuf_r[1] <= rem[15:0];
                        wbuf_r[2] <= quo[31:16];
                        wbuf_r[3] <= quo[15:0];
                        cc_r <= (quo[31:0] == 32'h00000000) ? `PXMD_CC_ZERO :
                                quo[31] ? `PXMD_CC_NEG : `PXMD_CC_POS;
                    end
                end
                `PXMD_S_WR:
                begin
                    // Four results written Ra..Ra+3, one per cycle
                    rf_we_r <= 1'b1;
                    rf_waddr_r <= a_r + {2'h0, wr_n_r};
                    rf_wdata_r <= wbuf_r[wr_n_r];
                    wr_n_r <= wr_n_r + 2'h1;
                    if (wr_n_r == `PXMD_WR_LAST)
                    begin
                        state_r <= `PXMD_S_DONE;
                    end
                end
                `PXMD_S_DONE:
                begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    state_r <= `PXMD_S_IDLE;
                end
                default:
                begin
                    state_r <= `PXMD_S_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

endmodule // pxmd_core

// ### bench/pxmd_partner.sv
`timescale 1ns/10ps
// Register file and memory facing the core
module pxmd_partner (
    input wire clk,
    input wire rst,
    input wire slow,
    input wire [3:0] rf_raddr_r,
    output wire [15:0] rf_rdata,
    input wire rf_we_r,
    input wire [3:0] rf_waddr_r,
    input wire [15:0] rf_wdata_r,
    input wire mem_req_r,
    input wire mem_we_r,
    input wire [15:0] mem_addr_r,
    input wire [15:0] mem_wdata_r,
    output reg mem_ack,
    output wire [15:0] mem_rdata
);
    reg [15:0] rf [0:15];
    reg [15:0] mem [0:255];
    reg [1:0] dly_r;
    // Memory read data is junk outside the ack cycle, never the right word; register read data is always valid
    assign rf_rdata = rf[rf_raddr_r];
    assign mem_rdata = mem_ack ? mem[mem_addr_r[7:0]] : ~mem[mem_addr_r[7:0]];
    // One ack per word; slow mode inserts wait cycles
    always @(posedge clk)
    begin
        if (rst)
        begin
            mem_ack <= 1'b0;
            dly_r <= 2'h0;
        end
        else if (mem_req_r && !mem_ack && dly_r == 2'h0)
        begin
            mem_ack <= 1'b1;
            dly_r <= slow ? 2'h3 : 2'h0;
        end
        else
        begin
            mem_ack <= 1'b0;
            dly_r <= (dly_r != 2'h0) ? dly_r - 2'h1 : dly_r;
        end
    end
    // Writes land at the edge of the strobe
    always @(posedge clk)
    begin
        if (rf_we_r)
            rf[rf_waddr_r] <= rf_wdata_r;
        if (mem_ack && mem_we_r)
            mem[mem_addr_r[7:0]] <= mem_wdata_r;
    end
endmodule // pxmd_partner

// ### bench/pxmd_core_chk.sv
`timescale 1ns/10ps
`include "pxmd_regs.vh"
// Sequencing checks on the core ports
module pxmd_core_chk (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire start,
    input wire [5:0] opcode,
    input wire [1:0] form,
    input wire rf_we_r,
    input wire mem_req_r,
    input wire mem_we_r,
    input wire [15:0] mem_addr_r,
    input wire [15:0] mem_wdata_r,
    input wire mem_ack,
    input wire busy_r,
    input wire done_r,
    input wire undef_r,
    input wire cc_we_r,
    input wire [1:0] cc_r
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Accepted request
    wire acc = ce && start && !busy_r;
    sequence s_mul_acc;
        acc && opcode == `PXMD_OP_DMUL && form == `PXMD_FORM_RR;
    endsequence
    sequence s_mul_end;
        ##[6:10] cc_we_r ##[3:7] done_r;
    endsequence
    property p_mul_seq;
        s_mul_acc |-> s_mul_end;
    endproperty
    a_mul_seq: assert property (p_mul_seq) else $error("multiply sequence off");
    property p_done_pulse;
        done_r |=> !done_r;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    property p_undef_with_done;
        undef_r |-> done_r;
    endproperty
    a_undef_with_done: assert property (p_undef_with_done) else $error("undef without done");
    property p_undef_rk;
        acc && form == `PXMD_FORM_RK |-> ##[1:2] (done_r && undef_r);
    endproperty
    a_undef_rk: assert property (p_undef_rk) else $error("short literal not undefined");
    property p_undef_quiet;
        acc && form == `PXMD_FORM_RK |=> (!rf_we_r && !mem_req_r && !cc_we_r) [*3];
    endproperty
    a_undef_quiet: assert property (p_undef_quiet) else $error("undefined changed state");
    property p_mem_hold;
        mem_req_r && !mem_ack |=> mem_req_r && $stable(mem_addr_r) && $stable(mem_we_r) && $stable(mem_wdata_r);
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("memory request moved");
    property p_cc_change;
        $changed(cc_r) |-> cc_we_r;
    endproperty
    a_cc_change: assert property (p_cc_change) else $error("cc changed silently");
    property p_rr_nomem;
        acc && form == `PXMD_FORM_RR |=> !mem_req_r [*8];
    endproperty
    a_rr_nomem: assert property (p_rr_nomem) else $error("register form used memory");
    property p_rf_busy;
        rf_we_r |-> busy_r;
    endproperty
    a_rf_busy: assert property (p_rf_busy) else $error("register write while idle");
endmodule // pxmd_core_chk
bind pxmd_core pxmd_core_chk pxmd_core_chk_i (.*);

// ### bench/pxmd_core_tb.sv
`timescale 1ns/10ps
`include "pxmd_regs.vh"
module pxmd_core_tb;
    reg clk, rst, ce, start, slow;
    reg [5:0] opcode, map_idx;
    reg [1:0] form;
    reg [3:0] accum_reg_select, source_reg_select;
    reg [15:0] y_addr;
    wire [3:0] rf_raddr_r, rf_waddr_r;
    wire [15:0] rf_rdata, rf_wdata_r, mem_addr_r, mem_wdata_r, mem_rdata, map_data_r;
    wire rf_we_r, mem_req_r, mem_we_r, mem_ack, busy_r, done_r, undef_r, cc_we_r;
    wire [1:0] cc_r;
    integer n_mismatch, total_checks, cyc, k;
    reg [63:0] q;
    pxmd_core pxmd_core_i (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .start(start),
        .opcode(opcode),
        .form(form),
        .accum_reg_select(accum_reg_select),
        .source_reg_select(source_reg_select),
        .y_addr(y_addr),
        .rf_raddr_r(rf_raddr_r),
        .rf_rdata(rf_rdata),
        .rf_we_r(rf_we_r),
        .rf_waddr_r(rf_waddr_r),
        .rf_wdata_r(rf_wdata_r),
        .mem_req_r(mem_req_r),
        .mem_we_r(mem_we_r),
        .mem_addr_r(mem_addr_r),
        .mem_wdata_r(mem_wdata_r),
        .mem_ack(mem_ack),
        .mem_rdata(mem_rdata),
        .map_idx(map_idx),
        .map_data_r(map_data_r),
        .busy_r(busy_r),
        .done_r(done_r),
        .undef_r(undef_r),
        .cc_we_r(cc_we_r),
        .cc_r(cc_r)
    );
    pxmd_partner pxmd_partner_i (
        .clk(clk),
        .rst(rst),
        .slow(slow),
        .rf_raddr_r(rf_raddr_r),
        .rf_rdata(rf_rdata),
        .rf_we_r(rf_we_r),
        .rf_waddr_r(rf_waddr_r),
        .rf_wdata_r(rf_wdata_r),
        .mem_req_r(mem_req_r),
        .mem_we_r(mem_we_r),
        .mem_addr_r(mem_addr_r),
        .mem_wdata_r(mem_wdata_r),
        .mem_ack(mem_ack),
        .mem_rdata(mem_rdata)
    );
    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            n_mismatch = n_mismatch + 1;
            end_of_test;
        end
    end
    task end_of_test;
    begin
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    task chk(input [39:0] name, input [63:0] e, input [63:0] g);
    begin
        total_checks = total_checks + 1;
        if (g !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED %0s exp %h got %h", name, e, g);
        end
    end
    endtask
    // Four registers from a, wrapping mod 16
    function [63:0] rq(input [3:0] a);
        rq = {pxmd_partner_i.rf[a], pxmd_partner_i.rf[a + 4'h1], pxmd_partner_i.rf[a + 4'h2], pxmd_partner_i.rf[a + 4'h3]};
    endfunction
    task wq(input [3:0] a, input [63:0] v);
    begin
        for (k = 0; k < 4; k = k + 1)
            pxmd_partner_i.rf[a + k[3:0]] = v[63 - 16 * k -: 16];
    end
    endtask
    task wm(input [7:0] ad, input [31:0] v);
    begin
        pxmd_partner_i.mem[ad] = v[31:16];
        pxmd_partner_i.mem[ad + 8'h1] = v[15:0];
    end
    endtask
    // Issue one instruction and wait for its end
    task run(input [5:0] op, input [1:0] f, input [3:0] a, input [3:0] m, input [15:0] y);
    begin
        @(posedge clk);
        opcode <= op;
        form <= f;
        accum_reg_select <= a;
        source_reg_select <= m;
        y_addr <= y;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (k = 0; k < 100 && done_r !== 1'b1; k = k + 1)
            @(negedge clk);
        chk("done", 1'b1, done_r);
    end
    endtask
    task pg(input [5:0] idx, input [15:0] e);
    begin
        @(posedge clk);
        map_idx <= idx;
        @(posedge clk);
        @(negedge clk);
        chk("page", e, map_data_r);
    end
    endtask
    task md(input [5:0] op, input [1:0] f, input [3:0] a, input [3:0] m, input [15:0] y, input [63:0] e, input [1:0] c);
    begin
        run(op, f, a, m, y);
        chk("quad", e, rq(a));
        chk("cc", c, cc_r);
    end
    endtask
    task t_pg_rr;
    begin
        wq(1, 64'hFFC5_FFFF_0000_0000);
        run(`PXMD_OP_LDPG, `PXMD_FORM_RR, 1, 2, 0);
        pg(6'h05, 16'hFFFF & 16'h803F);
        run(`PXMD_OP_STPG, `PXMD_FORM_RR, 1, 3, 0);
        chk("rf", 16'h803F, pxmd_partner_i.rf[3]);
    end
    endtask
    task t_pg_ri;
    begin
        slow <= 1'b1;
        wq(1, 64'h0007_0010_0000_0000);
        wm(8'h10, 32'h1234_0000);
        run(`PXMD_OP_LDPG, `PXMD_FORM_RI, 1, 2, 0);
        pg(6'h07, 16'h0034);
        wq(2, 64'h0020_0000_0000_0000);
        run(`PXMD_OP_STPG, `PXMD_FORM_RI, 1, 2, 0);
        chk("mem", 16'h0034, pxmd_partner_i.mem[8'h20]);
    end
    endtask
    task t_pg_blk;
    begin
        slow <= 1'b0;
        wq(1, 64'h023E_0000_0000_0000);
        wm(8'h40, 32'h8001_0002);
        wm(8'h42, 32'hFFC3_1111);
        run(`PXMD_OP_LDPG, `PXMD_FORM_RX, 1, 0, 16'h0040);
        pg(6'h3E, 16'h8001);
        pg(6'h3F, 16'h0002);
        pg(6'h00, 16'h8003);
        wq(1, 64'hC03F_0000_0000_0000);
        wm(8'h50, 32'h0000_BEEF);
        run(`PXMD_OP_STPG, `PXMD_FORM_RX, 1, 0, 16'h0050);
        chk("mem", 16'h0002, pxmd_partner_i.mem[8'h50]);
        chk("mem", 16'hBEEF, pxmd_partner_i.mem[8'h51]);
    end
    endtask
    task t_muldiv;
    begin
        wq(2, 64'hFFFFFFFE_00000000);
        wq(8, 64'h00000003_00000000);
        q = 64'hFFFFFFFFFFFFFFFE * 64'h3;
        md(`PXMD_OP_DMUL, `PXMD_FORM_RR, 2, 8, 0, q, `PXMD_CC_NEG);
        wq(14, 64'h00000002_00000000);
        wm(8'h60, 32'h0001_0000);
        q = 64'h2 * 64'h10000;
        md(`PXMD_OP_DMUL, `PXMD_FORM_RX, 14, 0, 16'h0060, q, `PXMD_CC_POS);
        wq(4, 64'hFFFFFFFFFFFFFFF9);
        wq(10, 64'h00000002_00000000);
        md(`PXMD_OP_DDIV, `PXMD_FORM_RR, 4, 10, 0, {-32'sd1, -32'sd3}, `PXMD_CC_NEG);
        slow <= 1'b1;
        wq(6, 64'd9);
        wm(8'h70, 32'h0000_0004);
        md(`PXMD_OP_DDIV, `PXMD_FORM_RI, 6, 0, 16'h0070, {32'd1, 32'd2}, `PXMD_CC_POS);
        wm(8'h78, 32'h0000_0000);
        md(`PXMD_OP_DDIV, `PXMD_FORM_RX, 6, 0, 16'h0078, {32'd1, 32'd2}, `PXMD_CC_OVF);
    end
    endtask
    task t_undef;
        reg [5:0] op;
    begin
        for (op = `PXMD_OP_LDPG; op <= `PXMD_OP_DDIV; op = op + 6'h1)
        begin
            wq(0, 64'h1111_2222_3333_4444);
            run(op, `PXMD_FORM_RK, 0, 1, 16'h0040);
            chk("undef", 1'b1, undef_r);
            chk("quad", 64'h1111_2222_3333_4444, rq(0));
        end
    end
    endtask
    // Main sequence
    initial
    begin
        n_mismatch = 0;
        total_checks = 0;
        cyc = 0;
        {rst, ce, start, slow} = 4'h C;
        {opcode, map_idx, form, accum_reg_select, source_reg_select, y_addr} = 38'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_pg_rr;
        t_pg_ri;
        t_pg_blk;
        t_muldiv;
        t_undef;
        end_of_test;
    end
endmodule // pxmd_core_tb
